/* File: hw/urr_pkg.sv */
`default_nettype none
// Shared constants for the serial receiver
package urr_pkg;
  // APB byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  // Status bit positions
  localparam int ST_RXC = 7;
  localparam int ST_FE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_PE = 2;
  // Control bit positions and reset value
  localparam int CTRL_W = 8;
  localparam int CT_EN = 0;
  localparam int CT_DBL = 1;
  localparam int CT_ODD = 2;
  localparam int CT_PEN = 3;
  localparam int CT_STOP = 4;
  localparam int CT_SZ_LO = 5;
  localparam int CT_SZ_HI = 7;
  localparam logic [7:0] CTRL_RESET = 8'h60;
  // Character sizes: code 0..4 gives 5..9 data bits
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
  localparam int DATA_W = 9;
  // Sample states per bit and first voting sample
  localparam int CNT_W = 5;
  localparam logic [4:0] S_NORM = 5'h10;
  localparam logic [4:0] S_DBL = 5'h08;
  localparam logic [4:0] SF_NORM = 5'h08;
  localparam logic [4:0] SF_DBL = 5'h04;
  localparam logic [4:0] CNT_FIRST = 5'h01;
  // Buffer entry layout
  localparam int BUF_DEPTH = 2;
  localparam int ENT_W = 12;
  localparam int E_FE = 11;
  localparam int E_OVR = 10;
  localparam int E_PE = 9;
  // Receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} urr_state_type;
endpackage
`default_nettype wire

/* File: hw/urr_rxbuf.sv */
`timescale 1ns/1ps
`default_nettype none
// Small receive buffer; head entry comes out of a register
module urr_rxbuf #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [$clog2(DEPTH+1)-1:0] CNT_FULL = ($clog2(DEPTH+1))'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [PW-1:0] wptr, rptr;  // Write and read positions
  logic [PW-1:0] next_wptr, next_rptr;
  logic [$clog2(DEPTH+1)-1:0] next_count;
  logic do_push, do_pop;

  // Pointer and fill arithmetic
  always_comb begin
    do_push = push && (count != CNT_FULL);
    do_pop = pop && (count != '0);
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (flush) begin
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
    end else begin
      if (do_push) begin
        next_wptr = (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
      end
      if (do_pop) begin
        next_rptr = (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
        next_count = count - 1'b1;
      end
    end
  end

  // Register pointers, storage and head word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      rdata <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      rdata <= mem[rptr];
      if (do_push && !flush) begin
        mem[wptr] <= wdata;
      end
    end
  end
endmodule // urr_rxbuf
`default_nettype wire

/* File: hw/urr_receiver.sv */
// How it works
// - Error flags stored with their character
// - Status writes never change error flags
// - Error flags raise no interrupt
// - Frame error follows first stop bit
// - Only first stop bit is checked
// - Overrun on full buffer, waiting char, start
// - Overrun clears when frame moves into buffer
// - Parity error reads zero when checking off
// - Checker on by enable bit, odd select
// - Parity mismatch kept with its character
// - Disable stops reception and pin override
// - Disable empties the buffer
// - Complete flag shows buffer not empty
// - Sample 16x normal, 8x double speed
// - Start vote on 8-10 or 4-6
// - Resync per start, rejected start resumes search
// - Sixteen or eight states per bit
// - Each bit is a three sample majority
// - Vote window starts at 8 or 4
// - Stop after first stop bit vote
// - New start allowed right after stop vote
`timescale 1ns/1ps
`default_nettype none
module urr_receiver
  import urr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SAMPLE_TICK,
  input wire logic SERIAL_RECEIVE_PIN,
  output logic RX_PIN_OVERRIDE
);
  ////////////////////////////////////////////////////////////////
  // Helpers
  // Majority of three samples
  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
  // Odd parity of the data word
  function automatic logic xor_all(input logic [DATA_W-1:0] d);
    return ^d;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic rx_meta, rx_sync;  // Pin synchroniser stages
  logic rx_prev, next_rx_prev;  // Line level at previous tick
  urr_state_type state, next_state;  // Receiver phase
  logic [CNT_W-1:0] cnt, next_cnt;  // Sample state within a bit
  logic [3:0] bidx, next_bidx;  // Bit position after start
  logic [DATA_W-1:0] shift, next_shift;  // Assembled data bits
  logic pbit, next_pbit;  // Received parity bit
  logic v0, v1, next_v0, next_v1;  // First two voting samples
  logic [ENT_W-1:0] pend, next_pend;  // Completed char waiting
  logic pend_valid, next_pend_valid;
  logic ovr_latch, next_ovr_latch;  // Lost frame since last move
  logic [CTRL_W-1:0] ctrl, next_ctrl;  // Control register
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [ENT_W-1:0] head;  // Next readable entry
  logic [1:0] fill;  // Buffer fill level
  logic rx_en, par_en, par_odd, dbl;
  logic [CNT_W-1:0] s_len, s_first;  // Per-mode sample figures
  logic [3:0] nbits;  // Data bits per char
  logic [2:0] size_code;
  logic vote;  // Majority result this tick
  logic frame_done, frame_fe;  // Stop bit voted this tick
  logic start_det;  // Accepted falling edge
  logic full, push, pop, flush;
  logic apb_done, addr_ok;
  logic [ENT_W-1:0] frame_word;

  ////////////////////////////////////////////////////////////////
  // Configuration decode
  always_comb begin
    rx_en = ctrl[CT_EN];
    par_en = ctrl[CT_PEN];
    par_odd = ctrl[CT_ODD];
    dbl = ctrl[CT_DBL];
    s_len = dbl ? S_DBL : S_NORM;
    s_first = dbl ? SF_DBL : SF_NORM;
    size_code = ctrl[CT_SZ_HI:CT_SZ_LO];
    if (size_code > SIZE_CODE_MAX) begin
      size_code = SIZE_CODE_MAX;
    end
    nbits = DATA_BITS_MIN + {1'b0, size_code};
  end

  ////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= SERIAL_RECEIVE_PIN;
      rx_sync <= rx_meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Clock and data recovery
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bidx = bidx;
    next_shift = shift;
    next_pbit = pbit;
    next_v0 = v0;
    next_v1 = v1;
    next_rx_prev = rx_prev;
    frame_done = 1'b0;
    frame_fe = 1'b0;
    start_det = 1'b0;
    vote = majority3(v0, v1, rx_sync);
    if (!rx_en) begin
      // Disable drops any frame at once
      next_state = RX_IDLE;
      next_cnt = '0;
      next_rx_prev = rx_sync;
    end else if (SAMPLE_TICK) begin
      next_rx_prev = rx_sync;
      unique case (state)
        RX_IDLE: begin
          // Falling edge starts sample numbering at 1
          if (rx_prev && !rx_sync) begin
            next_state = RX_START;
            next_cnt = CNT_FIRST;
            next_bidx = '0;
            next_shift = '0;
            next_pbit = 1'b0;
            start_det = 1'b1;
          end
        end
        RX_START, RX_BITS: begin
          next_cnt = cnt + 1'b1;
          if (cnt == s_first) begin
            next_v0 = rx_sync;
          end
          if (cnt == s_first + 1'b1) begin
            next_v1 = rx_sync;
          end
          if (cnt == s_first + 5'h02) begin
            if (state == RX_START) begin
              // High majority means noise, go back to search
              if (vote) begin
                next_state = RX_IDLE;
              end
            end else if (bidx < nbits) begin
              next_shift[bidx] = vote;
            end else if (par_en && (bidx == nbits)) begin
              next_pbit = vote;
            end else begin
              // First stop bit ends the frame here
              frame_done = 1'b1;
              frame_fe = !vote;
              next_state = RX_IDLE;
            end
          end
          if (cnt == s_len) begin
            // Bit boundary
            next_cnt = CNT_FIRST;
            next_bidx = (state == RX_BITS) ? bidx + 1'b1 : '0;
            next_state = RX_BITS;
          end
        end
        default: begin
          next_state = RX_IDLE;
        end
      endcase
    end
  end

  // Register recovery state
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      state <= RX_IDLE;
      cnt <= '0;
      bidx <= '0;
      shift <= '0;
      pbit <= 1'b0;
      v0 <= 1'b0;
      v1 <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bidx <= next_bidx;
      shift <= next_shift;
      pbit <= next_pbit;
      v0 <= next_v0;
      v1 <= next_v1;
      rx_prev <= next_rx_prev;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Waiting character and overrun
  always_comb begin
    frame_word = '0;
    frame_word[DATA_W-1:0] = shift;
    frame_word[E_FE] = frame_fe;
    // Even when select is zero, odd when one
    frame_word[E_PE] = par_en && (xor_all(shift) ^ pbit ^ par_odd);
    full = (fill == 2'(BUF_DEPTH));
    flush = !rx_en;
    push = pend_valid && !full;
    next_pend = pend;
    next_pend_valid = pend_valid;
    next_ovr_latch = ovr_latch;
    if (!rx_en) begin
      next_pend_valid = 1'b0;
      next_ovr_latch = 1'b0;
    end else begin
      if (push) begin
        next_pend_valid = 1'b0;
        next_ovr_latch = 1'b0;
      end
      if (frame_done && (!pend_valid || push)) begin
        next_pend = frame_word;
        next_pend_valid = 1'b1;
      end
      // Set wins over the clear on a move
      if (start_det && full && pend_valid) begin
        next_ovr_latch = 1'b1;
      end
    end
  end

  // Register waiting character
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      pend <= '0;
      pend_valid <= 1'b0;
      ovr_latch <= 1'b0;
    end else begin
      pend <= next_pend;
      pend_valid <= next_pend_valid;
      ovr_latch <= next_ovr_latch;
    end
  end

  // Receive buffer, flags travel with the data
  urr_rxbuf #(
    .WIDTH(ENT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(MCLK),
    .rst_n(RSTN),
    .flush(flush),
    .push(push),
    .wdata({pend[E_FE], ovr_latch, pend[E_PE], pend[DATA_W-1:0]}),
    .pop(pop),
    .rdata(head),
    .count(fill)
  );

  ////////////////////////////////////////////////////////////////
  // APB slave, one wait state per access
  always_comb begin
    apb_done = PSEL && PENABLE && PREADY;
    addr_ok = (PADDR == REG_STATUS) || (PADDR == REG_DATA) || (PADDR == REG_CTRL);
    // Data read advances the buffer
    pop = apb_done && !PWRITE && (PADDR == REG_DATA);
    next_pready = PSEL && PENABLE && !PREADY;
    next_pslverr = next_pready && !addr_ok;
    next_prdata = '0;
    next_ctrl = ctrl;
    if (next_pready && !PWRITE) begin
      unique case (PADDR)
        REG_STATUS: begin
          next_prdata[ST_RXC] = (fill != '0);
          next_prdata[ST_FE] = (fill != '0) && head[E_FE];
          next_prdata[ST_OVR] = (fill != '0) && head[E_OVR];
          next_prdata[ST_PE] = (fill != '0) && head[E_PE] && par_en;
        end
        REG_DATA: begin
          next_prdata[DATA_W-1:0] = (fill != '0) ? head[DATA_W-1:0] : '0;
        end
        REG_CTRL: begin
          next_prdata[CTRL_W-1:0] = ctrl;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
    // Status writes hold no storage, so flags stay as they are
    if (apb_done && PWRITE && (PADDR == REG_CTRL)) begin
      next_ctrl = PWDATA[CTRL_W-1:0];
    end
  end

  // Register bus outputs and control; no interrupt output exists
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      ctrl <= CTRL_RESET;
      RX_PIN_OVERRIDE <= 1'b0;
    end else begin
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      ctrl <= next_ctrl;
      RX_PIN_OVERRIDE <= next_ctrl[CT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence s_edge_seen;
    state == RX_IDLE && rx_en && SAMPLE_TICK && rx_prev && !rx_sync;
  endsequence
  sequence s_stop_voted;
    state == RX_BITS && rx_en && SAMPLE_TICK && cnt == s_first + 5'h02 && bidx >= nbits
      && !(par_en && bidx == nbits);
  endsequence

  a_start_begins: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_edge_seen |=> state == RX_START && cnt == CNT_FIRST)
    else $error("falling edge did not start the start bit check");
  a_noise_reject: assert property (@(posedge MCLK) disable iff (!RSTN)
    (state == RX_START && rx_en && SAMPLE_TICK && cnt == s_first + 5'h02 && vote)
      |=> state == RX_IDLE)
    else $error("noisy start bit was not rejected");
  a_stop_to_idle: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_stop_voted |-> frame_done ##1 state == RX_IDLE)
    else $error("receiver did not finish after first stop bit");
  a_frame_err: assert property (@(posedge MCLK) disable iff (!RSTN)
    (frame_done && !pend_valid) |=> pend_valid && pend[E_FE] == $past(!majority3(v0, v1, rx_sync)))
    else $error("frame error does not follow stop bit");
  a_bit_wrap: assert property (@(posedge MCLK) disable iff (!RSTN)
    (state != RX_IDLE && rx_en && SAMPLE_TICK && cnt == s_len) |=> cnt == CNT_FIRST)
    else $error("sample state did not wrap at bit end");
  a_disable_flush: assert property (@(posedge MCLK) disable iff (!RSTN)
    !rx_en |=> fill == '0 && !pend_valid && state == RX_IDLE)
    else $error("disable did not empty the receiver");
  a_overrun_set: assert property (@(posedge MCLK) disable iff (!RSTN)
    (rx_en && start_det && full && pend_valid) |=> ovr_latch)
    else $error("overrun not flagged");
  a_overrun_clear: assert property (@(posedge MCLK) disable iff (!RSTN)
    (rx_en && push && !start_det) |=> !ovr_latch)
    else $error("overrun not cleared on move");
  a_pe_masked: assert property (@(posedge MCLK) disable iff (!RSTN)
    (PREADY && !PWRITE && PADDR == REG_STATUS && !par_en) |-> !PRDATA[ST_PE])
    else $error("parity error visible while checking off");
  a_rxc_level: assert property (@(posedge MCLK) disable iff (!RSTN)
    (PREADY && !PWRITE && PADDR == REG_STATUS) |-> PRDATA[ST_RXC] == ($past(fill) != '0))
    else $error("complete flag does not match buffer");
endmodule // urr_receiver
`default_nettype wire

/* File: testbench/urr_txmodel.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Remote serial sender: shifts a prepared frame out LSB first
module urr_txmodel (
  input wire logic clk,
  input wire logic tick,
  input wire logic go,
  input wire logic [11:0] frame,
  input wire logic [3:0] nb,
  input wire logic [4:0] spb,
  input wire logic [4:0] last_ticks,
  output logic line,
  output logic busy
);
  int idx; // Bit now on the line
  int cnt; // Ticks spent on that bit
  // Line idles high between frames
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // Each bit lasts spb ticks; the last one may be cut short for early restarts
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      idx = 0;
      cnt = 0;
      line <= frame[0];
    end else if (busy && tick) begin
      cnt = cnt + 1;
      if (cnt == ((idx == int'(nb) - 1) ? int'(last_ticks) : int'(spb))) begin
        cnt = 0;
        idx = idx + 1;
        if (idx == int'(nb)) begin
          busy <= 1'b0;
          line <= 1'b1;
        end else begin
          line <= frame[idx];
        end
      end
    end
  end
endmodule // urr_txmodel
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Self-checking bench for the serial receiver
module testbench;
  import urr_pkg::*;
  logic MCLK = 1'b0; // System clock
  logic RSTN = 1'b0; // Reset, active low
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic SAMPLE_TICK = 1'b0; // Oversampling strobe
  logic SERIAL_RECEIVE_PIN;
  logic RX_PIN_OVERRIDE;
  logic go = 1'b0; // Sender start pulse
  logic [11:0] frame = 12'hfff;
  logic [3:0] nb = 4'h1;
  logic [4:0] spb = 5'h10;
  logic [4:0] last = 5'h10;
  logic [4:0] sp = 5'h10; // Ticks per bit for the current mode
  logic busy;
  logic [1:0] tdiv = 2'h0;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////
  // Clock and a strobe every fourth cycle
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    tdiv <= tdiv + 2'h1;
    SAMPLE_TICK <= (tdiv == 2'h3);
  end
  urr_receiver urr_receiver_i (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SAMPLE_TICK(SAMPLE_TICK), .SERIAL_RECEIVE_PIN(SERIAL_RECEIVE_PIN),
    .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE));
  urr_txmodel urr_txmodel_i (.clk(MCLK), .tick(SAMPLE_TICK), .go(go), .frame(frame), .nb(nb),
    .spb(spb), .last_ticks(last), .line(SERIAL_RECEIVE_PIN), .busy(busy));
  ////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wrctrl(input logic [7:0] v);
    apb(1'b1, REG_CTRL, {24'h0, v});
  endtask
  // Expected status word
  function automatic logic [31:0] stx(input logic c, input logic f, input logic o, input logic p);
    logic [31:0] v;
    v = 32'h0;
    v[ST_RXC] = c;
    v[ST_FE] = f;
    v[ST_OVR] = o;
    v[ST_PE] = p;
    return v;
  endfunction
  // Frame: start, n data bits, optional parity (even unless odd), stop
  function automatic logic [11:0] mkf(input logic [8:0] d, input int n, input logic pen,
    input logic odd, input logic bad, input logic stopv);
    logic [11:0] f;
    f = 12'hffe;
    for (int i = 0; i < n; i++) begin
      f[1 + i] = d[i];
    end
    if (pen) begin
      f[1 + n] = ^(d & (9'h1ff >> (9 - n))) ^ odd ^ bad;
    end
    f[1 + n + int'(pen)] = stopv;
    return f;
  endfunction
  // Raw frame send, waits until the sender is idle again
  task automatic send(input logic [11:0] f, input int n, input logic [4:0] lt);
    int k;
    @(posedge MCLK);
    frame <= f;
    nb <= 4'(n);
    spb <= sp;
    last <= lt;
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    @(posedge MCLK);
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(posedge MCLK);
      k++;
    end
    if (k >= 5000) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic sendc(input logic [8:0] d, input int n, input logic pen, input logic odd,
    input logic bad, input logic stopv, input logic [4:0] lt);
    send(mkf(d, n, pen, odd, bad, stopv), n + 2 + int'(pen), lt);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [8:0] d [4];
    int k;
    void'($urandom(27988));
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    rdchk(REG_CTRL, 32'h60);
    rdchk(REG_STATUS, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk({31'h0, RX_PIN_OVERRIDE}, 32'h0);
    // Every character size, normal speed
    for (int sz = 0; sz < 5; sz++) begin
      wrctrl({3'(sz), 5'h01});
      d[0] = 9'($urandom);
      sendc(d[0], 5 + sz, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
      rdchk(REG_STATUS, stx(1, 0, 0, 0));
      rdchk(REG_DATA, {23'h0, d[0] & (9'h1ff >> (4 - sz))});
    end
    rdchk(REG_STATUS, 32'h0);
    @(posedge MCLK);
    chk({31'h0, RX_PIN_OVERRIDE}, 32'h1);
    // Bad stop bit with two-stop setting; status writes change nothing
    wrctrl(8'h71);
    sendc(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b0, 5'h10);
    rdchk(REG_STATUS, stx(1, 1, 0, 0));
    apb(1'b1, REG_STATUS, 32'h0);
    rdchk(REG_STATUS, stx(1, 1, 0, 0));
    rdchk(REG_DATA, 32'h0a5);
    // Parity even and odd, good and bad
    for (int m = 0; m < 4; m++) begin
      wrctrl(8'h69 | (8'(m & 1) << 2));
      d[0] = 9'($urandom) & 9'h0ff;
      sendc(d[0], 8, 1'b1, m[0], m[1], 1'b1, 5'h10);
      rdchk(REG_STATUS, stx(1, 0, 0, m[1]));
      rdchk(REG_DATA, {23'h0, d[0]});
    end
    // Stored parity error reads zero once checking is off
    wrctrl(8'h69);
    sendc(9'h03c, 8, 1'b1, 1'b0, 1'b1, 1'b1, 5'h10);
    wrctrl(8'h61);
    rdchk(REG_STATUS, stx(1, 0, 0, 0));
    rdchk(REG_DATA, 32'h03c);
    // Double speed
    sp = 5'h08;
    wrctrl(8'h63);
    for (int i = 0; i < 3; i++) begin
      d[0] = 9'($urandom) & 9'h0ff;
      sendc(d[0], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h08);
      rdchk(REG_DATA, {23'h0, d[0]});
    end
    // Short low spikes rejected, then a real frame
    sp = 5'h10;
    wrctrl(8'h61);
    send(12'hffe, 1, 5'h03);
    send(12'hffe, 1, 5'h07);
    rdchk(REG_STATUS, 32'h0);
    sendc(9'h0c3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk(REG_DATA, 32'h0c3);
    // Next start right after the stop vote
    sendc(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h0b);
    sendc(9'h0e1, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk(REG_DATA, 32'h05a);
    rdchk(REG_DATA, 32'h0e1);
    // Overrun: two buffered, one waiting, fourth start
    for (int i = 0; i < 4; i++) begin
      d[i] = 9'($urandom) & 9'h0ff;
      sendc(d[i], 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    end
    for (int i = 0; i < 3; i++) begin
      rdchk(REG_STATUS, stx(1, 0, i == 2, 0));
      rdchk(REG_DATA, {23'h0, d[i]});
    end
    rdchk(REG_STATUS, 32'h0);
    sendc(9'h011, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk(REG_STATUS, stx(1, 0, 0, 0));
    // Flush by reading until empty
    sendc(9'h022, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    k = 0;
    do begin
      apb(1'b0, REG_DATA, 32'h0);
      k++;
      apb(1'b0, REG_STATUS, 32'h0);
    end while (rd[ST_RXC] !== 1'b0 && k < 4);
    chk(32'(k), 32'h2);
    rdchk(REG_DATA, 32'h0);
    // Disable with a full buffer and a frame in flight
    sendc(9'h033, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    sendc(9'h044, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    fork
      sendc(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
      begin
        repeat (300) @(posedge MCLK);
        wrctrl(8'h60);
      end
    join
    @(posedge MCLK);
    chk({31'h0, RX_PIN_OVERRIDE}, 32'h0);
    rdchk(REG_STATUS, 32'h0);
    rdchk(REG_DATA, 32'h0);
    wrctrl(8'h61);
    sendc(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk(REG_STATUS, stx(1, 0, 0, 0));
    rdchk(REG_DATA, 32'h066);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
